// >>> hdl/ddrsp_map.vh
// Constants shared by the burst-of-two memory port files
`ifndef DDRSP_MAP_VH
`define DDRSP_MAP_VH

// Pin widths (wide variant; the narrow variant uses the low half)
`define DDRSP_DATA_W      36
`define DDRSP_NARROW_W    18
`define DDRSP_ADDR_W      18
`define DDRSP_LANES       4
`define DDRSP_LANE_W      9
`define DDRSP_NARROW_MASK 36'h0_0003_ffff
`define DDRSP_WIDE_MASK   36'hf_ffff_ffff
`define DDRSP_NARROW_LANE 4'h3
`define DDRSP_WIDE_LANE   4'hf

// Storage window: word index is {low address bits, burst beat}
`define DDRSP_MEM_IDX_W   4
`define DDRSP_MEM_WORDS   16
`define DDRSP_ADDR_IDX_W  3

// Write buffer between the link and the array
`define DDRSP_FIFO_DEPTH  16
`define DDRSP_FIFO_AW     4
`define DDRSP_WENT_W      44
`define DDRSP_WENT_IDX_LO 40
`define DDRSP_WENT_DAT_LO 4

// Width of the pin synchroniser bundle
`define DDRSP_SYNC_W      64

// Delay-lock loop: lock time counted in rising input-clock edges
`define DDRSP_LOCK_EDGES  12'h800
`define DDRSP_LOCK_W      12

// Cycles after reset release before the width strap is taken
`define DDRSP_STRAP_WAIT  2'h3

`endif

// >>> hdl/ddrsp_sync.v
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
`default_nettype none

module ddrsp_sync #(
   parameter W = 8
) (
   input  wire         core_clk,  // Core clock
   input  wire         resetn,    // Synchronous reset, active low
   input  wire [W-1:0] async_in,  // Pins from outside the clock domain
   output reg  [W-1:0] sync_out   // Second stage, safe to use
);

   reg [W-1:0] stage1;

   // The first stage is read by the second stage only
   always @(posedge core_clk) begin
      if (!resetn) begin
         stage1   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // ddrsp_sync

`default_nettype wire

// >>> hdl/ddrsp_fifo.v
// Parameterised first-in first-out buffer in flip-flops
`timescale 1ns/1ns
`default_nettype none

module ddrsp_fifo #(
   parameter W     = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire         core_clk,   // Core clock
   input  wire         resetn,     // Synchronous reset, active low
   input  wire         in_valid,   // Word offered
   output wire         in_ready,   // Room for a word
   input  wire [W-1:0] in_data,    // Offered word
   output wire         out_valid,  // Word available
   input  wire         out_ready,  // Drain takes the word
   output wire [W-1:0] out_data    // Oldest word
);

   localparam [AW:0] FULL_CNT = DEPTH[AW:0];

   reg [W-1:0]  mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0]   count;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (count != FULL_CNT);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];

   always @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

endmodule // ddrsp_fifo

`default_nettype wire

// >>> hdl/ddrsp_port.v
// Memory-side port of a common-I/O double-data-rate burst-of-two static memory
`timescale 1ns/1ns
`default_nettype none
`include "ddrsp_map.vh"

//////////////////////////////////////////////////////////////////////////////
// How it works
// - Commands taken only on true clock rise
// - Write beats taken on both clock rises
// - Echo strobes toggle always, even when idle
// - Echo edges move with read data
// - Bypass low stops loop, clears lock
// - Bypass high runs loop until lock
// - Loop off gives one-cycle read latency
// - Valid flag high with data, echo aligned
// - Address registered on true clock rise
// - Address ignored unless load is low
// - Data pins driven on reads, inputs otherwise
// - Narrow variant uses low eighteen bits only
// - Direction high reads, low writes when loading
// - Loop on: first beat two cycles later
// - Idle cycle lets running read finish
// - Byte stored only when its enable low
module ddrsp_port (
   input  wire                      core_clk,          // Core clock, 25 MHz
   input  wire                      resetn,            // Synchronous reset, active low
   input  wire                      ref_timing_pos,    // True input clock pin
   input  wire                      ref_timing_neg,    // Complement input clock pin
   input  wire                      load_cycle_n,      // Load strobe, active low
   input  wire                      access_dir,        // High read, low write
   input  wire [`DDRSP_ADDR_W-1:0]  sync_addr,         // Burst address
   input  wire [`DDRSP_LANES-1:0]   byte_write_n,      // Byte enables, active low
   input  wire                      dll_bypass_n,      // Low bypasses the delay loop
   input  wire                      narrow_bus,        // Strap: high for 18-bit variant
   input  wire [`DDRSP_DATA_W-1:0]  data_pins_in,      // Data pin levels
   output reg  [`DDRSP_DATA_W-1:0]  data_pins_out,     // Data pin drive value
   output reg  [`DDRSP_DATA_W-1:0]  data_pins_oe,      // Data pin enables, high drives
   output reg                       echo_strobe_pos,   // Echo of true clock
   output reg                       echo_strobe_neg,   // Echo of complement clock
   output reg                       output_valid_flag, // Read data on the pins
   output reg                       dll_locked,        // Delay loop has locked
   output reg                       wbuf_stall         // Write buffer full
);

   //////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and clock edge detection

   wire [`DDRSP_SYNC_W-1:0] pins_raw = {ref_timing_neg, ref_timing_pos, load_cycle_n, access_dir,
                                       dll_bypass_n, narrow_bus, sync_addr, byte_write_n, data_pins_in};
   wire [`DDRSP_SYNC_W-1:0] pins_s;

   ddrsp_sync #(
      .W        (`DDRSP_SYNC_W)
   ) u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   wire                     kn_s       = pins_s[63];
   wire                     k_s        = pins_s[62];
   wire                     load_n_s   = pins_s[61];
   wire                     dir_s      = pins_s[60];
   wire                     bypass_n_s = pins_s[59];
   wire                     narrow_s   = pins_s[58];
   wire [`DDRSP_ADDR_W-1:0] addr_s     = pins_s[57:40];
   wire [`DDRSP_LANES-1:0]  bw_n_s     = pins_s[39:36];
   wire [`DDRSP_DATA_W-1:0] din_s      = pins_s[35:0];

   reg k_prev;
   reg kn_prev;

   // All pins share one synchroniser delay, so they stay aligned to the clocks
   wire k_rise  = k_s & ~k_prev;
   wire kn_rise = kn_s & ~kn_prev;

   always @(posedge core_clk) begin
      if (!resetn) begin
         k_prev  <= 1'b0;
         kn_prev <= 1'b0;
      end else begin
         k_prev  <= k_s;
         kn_prev <= kn_s;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Width strap, taken once the synchroniser holds the real level

   reg [1:0] strap_wait;
   reg       narrow_mode;

   always @(posedge core_clk) begin
      if (!resetn) begin
         strap_wait  <= 2'h0;
         narrow_mode <= 1'b0;
      end else if (strap_wait != `DDRSP_STRAP_WAIT) begin
         strap_wait <= strap_wait + 2'h1;
         if (strap_wait == `DDRSP_STRAP_WAIT - 2'h1) begin
            narrow_mode <= narrow_s;
         end
      end
   end

   wire [`DDRSP_LANES-1:0]  lane_mask = narrow_mode ? `DDRSP_NARROW_LANE : `DDRSP_WIDE_LANE;
   wire [`DDRSP_DATA_W-1:0] pin_mask  = narrow_mode ? `DDRSP_NARROW_MASK : `DDRSP_WIDE_MASK;

   //////////////////////////////////////////////////////////////////////////
   // Command decode

   wire load_now  = k_rise & ~load_n_s;
   wire cmd_read  = load_now & dir_s;
   wire cmd_write = load_now & ~dir_s;

   //////////////////////////////////////////////////////////////////////////
   // Delay-lock loop model

   reg [`DDRSP_LOCK_W-1:0] lock_cnt;

   always @(posedge core_clk) begin
      if (!resetn) begin
         lock_cnt   <= {`DDRSP_LOCK_W{1'b0}};
         dll_locked <= 1'b0;
      end else if (!bypass_n_s) begin
         lock_cnt   <= {`DDRSP_LOCK_W{1'b0}};
         dll_locked <= 1'b0;
      end else if (k_rise) begin
         if (lock_cnt != `DDRSP_LOCK_EDGES) begin
            lock_cnt <= lock_cnt + {{(`DDRSP_LOCK_W-1){1'b0}}, 1'b1};
         end
         dll_locked <= (lock_cnt == `DDRSP_LOCK_EDGES);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Write path: late write beats into the write buffer

   reg                          wr_pend;
   reg [`DDRSP_ADDR_IDX_W-1:0]  wr_addr;
   reg                          wr_beat1;
   reg [`DDRSP_ADDR_IDX_W-1:0]  wb_addr;
   reg                          fifo_in_valid;
   reg [`DDRSP_WENT_W-1:0]      fifo_in_data;
   wire                         fifo_in_ready;
   wire                         fifo_out_valid;
   wire                         fifo_out_ready;
   wire [`DDRSP_WENT_W-1:0]     fifo_out_data;

   wire [`DDRSP_LANES-1:0] beat_be = ~bw_n_s & lane_mask;

   always @(posedge core_clk) begin
      if (!resetn) begin
         wr_pend       <= 1'b0;
         wr_addr       <= {`DDRSP_ADDR_IDX_W{1'b0}};
         wr_beat1      <= 1'b0;
         wb_addr       <= {`DDRSP_ADDR_IDX_W{1'b0}};
         fifo_in_valid <= 1'b0;
         fifo_in_data  <= {`DDRSP_WENT_W{1'b0}};
         wbuf_stall    <= 1'b0;
      end else begin
         fifo_in_valid <= 1'b0;
         wbuf_stall    <= ~fifo_in_ready;
         if (k_rise) begin
            if (wr_pend) begin
               fifo_in_valid <= 1'b1;
               fifo_in_data  <= {wr_addr, 1'b0, din_s & pin_mask, beat_be};
               wr_beat1      <= 1'b1;
               wb_addr       <= wr_addr;
            end else begin
               wr_beat1 <= 1'b0;
            end
            wr_pend <= cmd_write;
            if (cmd_write) begin
               wr_addr <= addr_s[`DDRSP_ADDR_IDX_W-1:0];
            end
         end else if (kn_rise && wr_beat1) begin
            fifo_in_valid <= 1'b1;
            fifo_in_data  <= {wb_addr, 1'b1, din_s & pin_mask, beat_be};
            wr_beat1      <= 1'b0;
         end
      end
   end

   ddrsp_fifo #(
      .W         (`DDRSP_WENT_W),
      .DEPTH     (`DDRSP_FIFO_DEPTH),
      .AW        (`DDRSP_FIFO_AW)
   ) u_wbuf (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   //////////////////////////////////////////////////////////////////////////
   // Storage array; the drain yields to output loading on clock edges

   reg [`DDRSP_DATA_W-1:0] mem [0:`DDRSP_MEM_WORDS-1];
   integer                 lane;

   assign fifo_out_ready = ~(k_rise | kn_rise);

   wire [`DDRSP_MEM_IDX_W-1:0] drain_idx = fifo_out_data[`DDRSP_WENT_W-1:`DDRSP_WENT_IDX_LO];
   wire [`DDRSP_DATA_W-1:0]    drain_dat = fifo_out_data[`DDRSP_WENT_IDX_LO-1:`DDRSP_WENT_DAT_LO];
   wire [`DDRSP_LANES-1:0]     drain_be  = fifo_out_data[`DDRSP_LANES-1:0];

   always @(posedge core_clk) begin
      if (fifo_out_valid && fifo_out_ready) begin
         for (lane = 0; lane < `DDRSP_LANES; lane = lane + 1) begin
            if (drain_be[lane]) begin
               mem[drain_idx][lane*`DDRSP_LANE_W +: `DDRSP_LANE_W] <=
                  drain_dat[lane*`DDRSP_LANE_W +: `DDRSP_LANE_W];
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read pipeline; it runs on regardless of later idle cycles

   reg                         rd_cmd1;
   reg                         rd_cmd2;
   reg [`DDRSP_ADDR_IDX_W-1:0] rd_addr1;
   reg [`DDRSP_ADDR_IDX_W-1:0] rd_addr2;

   always @(posedge core_clk) begin
      if (!resetn) begin
         rd_cmd1  <= 1'b0;
         rd_cmd2  <= 1'b0;
         rd_addr1 <= {`DDRSP_ADDR_IDX_W{1'b0}};
         rd_addr2 <= {`DDRSP_ADDR_IDX_W{1'b0}};
      end else if (k_rise) begin
         rd_cmd1  <= cmd_read;
         rd_addr1 <= addr_s[`DDRSP_ADDR_IDX_W-1:0];
         rd_cmd2  <= rd_cmd1;
         rd_addr2 <= rd_addr1;
      end
   end

   // Loop off launches one cycle after the command, loop on two
   wire                         launch      = bypass_n_s ? rd_cmd2 : rd_cmd1;
   wire [`DDRSP_ADDR_IDX_W-1:0] launch_addr = bypass_n_s ? rd_addr2 : rd_addr1;

   //////////////////////////////////////////////////////////////////////////
   // Output burst sequencer

   localparam [2:0] OUT_IDLE  = 3'h1;
   localparam [2:0] OUT_BEAT0 = 3'h2;
   localparam [2:0] OUT_BEAT1 = 3'h4;

   reg [2:0]                   out_state;
   reg [`DDRSP_ADDR_IDX_W-1:0] out_addr;

   // Data, valid and echoes all update in the same core cycle, which keeps them edge aligned
   always @(posedge core_clk) begin
      if (!resetn) begin
         out_state         <= OUT_IDLE;
         out_addr          <= {`DDRSP_ADDR_IDX_W{1'b0}};
         data_pins_out     <= {`DDRSP_DATA_W{1'b0}};
         data_pins_oe      <= {`DDRSP_DATA_W{1'b0}};
         output_valid_flag <= 1'b0;
         echo_strobe_pos   <= 1'b0;
         echo_strobe_neg   <= 1'b1;
      end else begin
         if (k_rise) begin
            echo_strobe_pos <= 1'b1;
            echo_strobe_neg <= 1'b0;
         end else if (kn_rise) begin
            echo_strobe_pos <= 1'b0;
            echo_strobe_neg <= 1'b1;
         end
         case (out_state)
            OUT_IDLE, OUT_BEAT1: begin
               if (k_rise) begin
                  if (launch) begin
                     out_state         <= OUT_BEAT0;
                     out_addr          <= launch_addr;
                     data_pins_out     <= mem[{launch_addr, 1'b0}] & pin_mask;
                     data_pins_oe      <= pin_mask;
                     output_valid_flag <= 1'b1;
                  end else begin
                     out_state         <= OUT_IDLE;
                     data_pins_out     <= {`DDRSP_DATA_W{1'b0}};
                     data_pins_oe      <= {`DDRSP_DATA_W{1'b0}};
                     output_valid_flag <= 1'b0;
                  end
               end
            end
            OUT_BEAT0: begin
               if (kn_rise) begin
                  out_state     <= OUT_BEAT1;
                  data_pins_out <= mem[{out_addr, 1'b1}] & pin_mask;
               end
            end
            default: begin
               out_state <= OUT_IDLE;
            end
         endcase
      end
   end

endmodule // ddrsp_port

`default_nettype wire

// >>> verification/ddrsp_port_properties.sv
// Concurrent checks on the pins of the memory port
`timescale 1ns/1ns
`default_nettype none
`include "ddrsp_map.vh"

module ddrsp_port_props (
   input wire logic                     core_clk,          // Core clock
   input wire logic                     resetn,            // Reset, active low
   input wire logic                     ref_timing_pos,    // True input clock
   input wire logic                     ref_timing_neg,    // Complement input clock
   input wire logic                     dll_bypass_n,      // Loop bypass
   input wire logic                     narrow_bus,        // Width strap
   input wire logic [`DDRSP_DATA_W-1:0] data_pins_out,     // Drive value
   input wire logic [`DDRSP_DATA_W-1:0] data_pins_oe,      // Drive enables
   input wire logic                     echo_strobe_pos,   // Echo true
   input wire logic                     echo_strobe_neg,   // Echo complement
   input wire logic                     output_valid_flag, // Read data valid
   input wire logic                     dll_locked         // Loop locked
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic [`DDRSP_DATA_W-1:0] lane_mask = narrow_bus ? `DDRSP_NARROW_MASK : `DDRSP_WIDE_MASK;
   //////////////////////////////////////////////////////////////////////////////
   // Pin edges reach the outputs through two sync flops and an edge detect
   sequence s_echo_up; ##[2:6] $rose(echo_strobe_pos); endsequence
   sequence s_echo_down; ##[2:6] $fell(echo_strobe_pos); endsequence
   sequence s_burst; output_valid_flag [*7]; endsequence
   property p_echo_pair; echo_strobe_neg == !echo_strobe_pos; endproperty
   property p_echo_rise; $rose(ref_timing_pos) |-> s_echo_up; endproperty
   property p_echo_fall; $rose(ref_timing_neg) |-> s_echo_down; endproperty
   property p_valid_edge; ($rose(output_valid_flag) || $fell(output_valid_flag)) |-> $rose(echo_strobe_pos); endproperty
   property p_data_edge; output_valid_flag && $changed(data_pins_out) |-> $changed(echo_strobe_pos); endproperty
   property p_oe_read; output_valid_flag |-> data_pins_oe == lane_mask; endproperty
   property p_oe_idle; !output_valid_flag |-> data_pins_oe == 36'h0; endproperty
   property p_bypass_clear; (!dll_bypass_n) [*5] |-> !dll_locked; endproperty
   property p_valid_burst; $rose(output_valid_flag) |-> s_burst; endproperty
   a_echo_pair: assert property (p_echo_pair) else $error("echo strobes not complementary");
   a_echo_rise: assert property (p_echo_rise) else $error("echo missed true clock rise");
   a_echo_fall: assert property (p_echo_fall) else $error("echo missed complement rise");
   a_valid_edge: assert property (p_valid_edge) else $error("valid edge not on echo edge");
   a_data_edge: assert property (p_data_edge) else $error("read data moved off echo edge");
   a_oe_read: assert property (p_oe_read) else $error("enables wrong during read");
   a_oe_idle: assert property (p_oe_idle) else $error("pins driven outside read");
   a_bypass_clear: assert property (p_bypass_clear) else $error("lock kept while bypassed");
   a_valid_burst: assert property (p_valid_burst) else $error("valid burst cut short");
endmodule // ddrsp_port_props

bind ddrsp_port ddrsp_port_props u_props (.core_clk(core_clk), .resetn(resetn), .ref_timing_pos(ref_timing_pos),
   .ref_timing_neg(ref_timing_neg), .dll_bypass_n(dll_bypass_n), .narrow_bus(narrow_bus),
   .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .echo_strobe_pos(echo_strobe_pos),
   .echo_strobe_neg(echo_strobe_neg), .output_valid_flag(output_valid_flag), .dll_locked(dll_locked));
`default_nettype wire

// >>> verification/ddrsp_ctrl_model.sv
// Behavioural memory controller on the link side of the port
`timescale 1ns/1ns
`default_nettype none
`include "ddrsp_map.vh"

module ddrsp_ctrl_model (
   input  wire logic                     core_clk,       // Core clock
   input  wire logic [`DDRSP_DATA_W-1:0] dev_out,        // Memory drive value
   input  wire logic [`DDRSP_DATA_W-1:0] dev_oe,         // Memory drive enables
   input  wire logic                     dev_valid,      // Memory read valid
   output var  logic                     ref_timing_pos, // True input clock
   output var  logic                     ref_timing_neg, // Complement input clock
   output var  logic                     load_cycle_n,   // Load strobe
   output var  logic                     access_dir,     // High read
   output var  logic [`DDRSP_ADDR_W-1:0] sync_addr,      // Address
   output var  logic [`DDRSP_LANES-1:0]  byte_write_n,   // Byte enables
   output wire logic [`DDRSP_DATA_W-1:0] data_pins_in    // Resolved data wire
);
   logic                     host_oe = 1'b0;
   logic [`DDRSP_DATA_W-1:0] host_d = 36'h0;
   logic                     flt = 1'b0;
   initial begin
      ref_timing_pos = 1'b0;
      ref_timing_neg = 1'b1;
      load_cycle_n = 1'b1;
      access_dir = 1'b1;
      sync_addr = 18'h0;
      byte_write_n = 4'hf;
   end
   always @(posedge core_clk) flt <= ~flt;
   // Undriven wire moves every cycle so a stale value never passes for data
   assign data_pins_in = (dev_oe & dev_out) | (~dev_oe & (host_oe ? host_d : {18{flt, ~flt}}));
   //////////////////////////////////////////////////////////////////////////////
   // One link cycle of eight core cycles, from phase 6 to phase 5
   task automatic link_cycle(input logic ld_n, input logic dir, input logic [17:0] addr, input logic drv,
         input logic [35:0] d0, input logic [3:0] b0, input logic [35:0] d1, input logic [3:0] b1,
         output logic [35:0] qb, output logic vb, output logic [35:0] qa, output logic va);
      integer ph;
      for (ph = 6; ph < 14; ph = ph + 1) begin
         @(negedge core_clk);
         case (ph % 8)
            6: begin
               load_cycle_n <= ld_n;
               access_dir <= dir;
               sync_addr <= addr;
               host_oe <= drv;
               host_d <= d0;
               byte_write_n <= drv ? b0 : 4'hf;
            end
            0: begin
               ref_timing_pos <= 1'b1;
               ref_timing_neg <= 1'b0;
            end
            2: begin
               host_d <= d1;
               byte_write_n <= drv ? b1 : 4'hf;
               qb = dev_out;
               vb = dev_valid;
            end
            4: begin
               ref_timing_pos <= 1'b0;
               ref_timing_neg <= 1'b1;
            end
            5: begin
               qa = dev_out;
               va = dev_valid;
            end
            default: ;
         endcase
      end
   endtask
endmodule // ddrsp_ctrl_model
`default_nettype wire

// >>> verification/ddrsp_port_tb.sv
// Self-checking bench for the memory port and its write buffer
`timescale 1ns/1ns
`default_nettype none
`include "ddrsp_map.vh"

module ddrsp_port_tb;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic dll_bypass_n = 1'b1;
   logic narrow_bus = 1'b0;
   wire logic rtp, rtn, ld_n, dir, eps, epn, vld, dll_locked, stall;
   wire logic [17:0] addr;
   wire logic [3:0] bw_n;
   wire logic [35:0] din, dout, doe;
   integer fail_count = 0;
   integer checks = 0;
   logic [35:0] qa, qb;
   logic va, vb;
   logic [35:0] mem_exp [0:15];

   always #20 core_clk = ~core_clk;

   ddrsp_port dut (.core_clk(core_clk), .resetn(resetn), .ref_timing_pos(rtp), .ref_timing_neg(rtn),
      .load_cycle_n(ld_n), .access_dir(dir), .sync_addr(addr), .byte_write_n(bw_n), .dll_bypass_n(dll_bypass_n),
      .narrow_bus(narrow_bus), .data_pins_in(din), .data_pins_out(dout), .data_pins_oe(doe),
      .echo_strobe_pos(eps), .echo_strobe_neg(epn), .output_valid_flag(vld), .dll_locked(dll_locked),
      .wbuf_stall(stall));
   ddrsp_ctrl_model mdl (.core_clk(core_clk), .dev_out(dout), .dev_oe(doe), .dev_valid(vld), .ref_timing_pos(rtp),
      .ref_timing_neg(rtn), .load_cycle_n(ld_n), .access_dir(dir), .sync_addr(addr), .byte_write_n(bw_n),
      .data_pins_in(din));
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic do_reset;
      @(negedge core_clk);
      resetn = 1'b0;
      repeat (20) @(negedge core_clk);
      resetn = 1'b1;
      repeat (4) @(negedge core_clk);
   endtask
   task automatic cyc(input logic l, input logic d, input logic [2:0] a, input logic drv,
         input logic [35:0] d0, input logic [3:0] b0, input logic [35:0] d1, input logic [3:0] b1);
      mdl.link_cycle(l, d, {15'h0, a}, drv, d0, b0, d1, b1, qb, vb, qa, va);
   endtask
   task automatic nop;
      cyc(1'b1, 1'b1, 3'h7, 1'b0, 36'h0, 4'hf, 36'h0, 4'hf);
   endtask
   // Data cycle carries an unloaded write to another word that must not land
   task automatic wr(input logic [2:0] a, input logic [35:0] d0, input logic [3:0] b0,
         input logic [35:0] d1, input logic [3:0] b1);
      integer i;
      cyc(1'b0, 1'b0, a, 1'b0, 36'h0, 4'hf, 36'h0, 4'hf);
      cyc(1'b1, 1'b0, a ^ 3'h3, 1'b1, d0, b0, d1, b1);
      for (i = 0; i < 4; i = i + 1) begin
         if (!b0[i] && !(narrow_bus && i > 1)) mem_exp[{a, 1'b0}][9*i +: 9] = d0[9*i +: 9];
         if (!b1[i] && !(narrow_bus && i > 1)) mem_exp[{a, 1'b1}][9*i +: 9] = d1[9*i +: 9];
      end
   endtask
   task automatic rd_chk(input logic [2:0] a, input integer lat);
      integer k;
      logic [35:0] lm;
      lm = narrow_bus ? `DDRSP_NARROW_MASK : `DDRSP_WIDE_MASK;
      cyc(1'b0, 1'b1, a, 1'b0, 36'h0, 4'hf, 36'h0, 4'hf);
      for (k = 1; k < lat; k = k + 1) begin
         nop;
         chk(va, 1'b0);
      end
      nop;
      chk(va, 1'b1);
      chk(qa & lm, mem_exp[{a, 1'b0}] & lm);
      nop;
      chk(qb & lm, mem_exp[{a, 1'b1}] & lm);
      chk(va, 1'b0);
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic t_rw;
      wr(3'h1, 36'h1_2345_6789, 4'h0, 36'h9_8765_4321, 4'h0);
      wr(3'h2, 36'h0_f0f0_f0f0, 4'h0, 36'h5_0a0a_0a0a, 4'h0);
      wr(3'h1, 36'hf_ffff_ffff, 4'ha, 36'h0, 4'h5);
      rd_chk(3'h1, 2);
      rd_chk(3'h2, 2);
      $display("read write test done");
   endtask
   task automatic t_lock;
      integer n;
      for (n = 0; n < 2200 && dll_locked !== 1'b1; n = n + 1) nop;
      chk(dll_locked, 1'b1);
      dll_bypass_n = 1'b0;
      nop;
      chk(dll_locked, 1'b0);
      rd_chk(3'h2, 1);
      dll_bypass_n = 1'b1;
      repeat (3) nop;
      chk(dll_locked, 1'b0);
      $display("loop bypass test done");
   endtask
   task automatic t_narrow;
      narrow_bus = 1'b1;
      do_reset;
      wr(3'h3, 36'hf_ffff_ffff, 4'h0, 36'ha_5a5a_5a5a, 4'h0);
      rd_chk(3'h3, 2);
      $display("narrow test done");
   endtask
   // Back-to-back writes: every data cycle but the last loads the next write, so the buffer takes a beat every half cycle
   task automatic t_fifo;
      integer i;
      logic [2:0] a;
      narrow_bus = 1'b0;
      do_reset;
      cyc(1'b0, 1'b0, 3'h4, 1'b0, 36'h0, 4'hf, 36'h0, 4'hf);
      for (i = 0; i < 4; i = i + 1) begin
         a = 3'h4 + i[2:0];
         mem_exp[{a, 1'b0}] = {32'haaaa_aaaa, i[3:0]};
         mem_exp[{a, 1'b1}] = {i[3:0], 32'h5555_5555};
         cyc(i > 2, 1'b0, a + 3'h1, 1'b1, mem_exp[{a, 1'b0}], 4'h0, mem_exp[{a, 1'b1}], 4'h0);
         chk(stall, 1'b0);
         chk(doe, 36'h0);
         chk(dout, 36'h0);
         chk(va, 1'b0);
      end
      for (i = 0; i < 4; i = i + 1) rd_chk(3'h4 + i[2:0], 2);
      chk(stall, 1'b0);
      $display("buffer test done");
   endtask
   initial begin
      do_reset;
      t_rw;
      t_lock;
      t_narrow;
      t_fifo;
      print_verdict;
   end
   initial begin
      #2000000;
      fail_count = fail_count + 1;
      print_verdict;
   end
endmodule // ddrsp_port_tb
`default_nettype wire
